/* logic/lic_pkg.sv */
// Package for the level interrupt controller: register map, field layout,
// reset values, source-to-level map and the carrier structs.
// Assumes one system clock and an 8-bit register port driven by the CPU core.
package lic_pkg;

	// Register offsets on the core register port
	localparam logic [7:0] LIC_OFS_LEVEL_REQUEST_STATUS = 8'hDC;
	localparam logic [7:0] LIC_OFS_LEVEL_MASK = 8'hDD;
	localparam logic [7:0] LIC_OFS_SYSTEM_MODE = 8'hDE;
	localparam logic [7:0] LIC_OFS_LEVEL_PRIORITY = 8'hFF;

	// System mode field positions
	localparam int LIC_SYM_GLOBAL_ENABLE_BIT = 0;
	localparam int LIC_SYM_FAST_ENABLE_BIT = 1;
	localparam int LIC_SYM_FAST_SEL_LO = 2;
	localparam int LIC_SYM_FAST_SEL_HI = 4;

	// Level priority field positions
	localparam int LIC_PRI_GROUP_A_BIT = 0;
	localparam int LIC_PRI_B_FIRST_BIT = 2;
	localparam int LIC_PRI_B_PAIR_BIT = 3;
	localparam int LIC_PRI_C_FIRST_BIT = 5;
	localparam int LIC_PRI_C_PAIR_BIT = 6;
	localparam int LIC_PRI_ORDER_HI_BIT = 7;
	localparam int LIC_PRI_ORDER_MID_BIT = 4;
	localparam int LIC_PRI_ORDER_LO_BIT = 1;

	// Reset values; mask, priority and fast select are undefined in hardware terms
	localparam logic [7:0] LIC_RST_LEVEL_REQUEST_STATUS = 8'h00;
	localparam logic [7:0] LIC_RST_LEVEL_MASK = 8'h00;
	localparam logic [7:0] LIC_RST_LEVEL_PRIORITY = 8'h00;
	localparam logic [2:0] LIC_RST_FAST_LEVEL_SELECT = 3'h0;
	localparam logic [7:0] LIC_RDATA_UNMAPPED = 8'h00;

	// Sources, numbered in vector order, grouped by level
	localparam int LIC_NUM_SOURCES = 26;
	localparam int LIC_NUM_LEVELS = 8;
	localparam int LIC_SRC_IDX_W = 5;
	localparam int LIC_SRC_BASE [LIC_NUM_LEVELS] = '{0, 3, 4, 6, 10, 14, 18, 22};
	localparam int LIC_SRC_COUNT [LIC_NUM_LEVELS] = '{3, 1, 2, 4, 4, 4, 4, 4};

	// Group order codes from priority bits 7, 4 and 1
	localparam logic [2:0] LIC_ORD_B_C_A = 3'h1;
	localparam logic [2:0] LIC_ORD_A_B_C = 3'h2;
	localparam logic [2:0] LIC_ORD_B_A_C = 3'h3;
	localparam logic [2:0] LIC_ORD_C_A_B = 3'h4;
	localparam logic [2:0] LIC_ORD_C_B_A = 3'h5;
	localparam logic [2:0] LIC_ORD_A_C_B = 3'h6;

	// Register access from the core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lic_reg_req_type;

	// Acknowledge handed to the core
	typedef struct packed {
		logic valid;
		logic [2:0] level;
		logic [LIC_SRC_IDX_W-1:0] source;
		logic fast;
	} lic_ack_type;

endpackage : lic_pkg

/* logic/lic_level_or.sv */
// Per-level request gather: ORs the enabled pending sources of one level and
// names the lowest-numbered active one. Assumes sources are numbered in vector order.
`timescale 1ns/100ps
`default_nettype none

module lic_level_or #(
	parameter int SRC_W = 26,
	parameter int BASE = 0,
	parameter int COUNT = 1,
	parameter int IDX_W = 5
) (
	// Sources
	input wire logic [SRC_W-1:0] pend_in,
	input wire logic [SRC_W-1:0] en_in,
	// Result
	output logic req_out,
	output logic [IDX_W-1:0] first_out
);

	// Scan from the highest source down so the lowest active one wins
	always_comb begin
		req_out = 1'b0;
		first_out = IDX_W'(BASE);
		for (int i = BASE + COUNT - 1; i >= BASE; i--) begin
			if (pend_in[i] && en_in[i]) begin
				req_out = 1'b1;
				first_out = IDX_W'(i);
			end
		end
	end

endmodule : lic_level_or

`default_nettype wire

/* logic/lic_group_arb.sv */
// Arbiter for one priority group of up to three levels. Entry 0 stands
// against entries 1 and 2 together; entries 1 and 2 are then ordered as a pair.
// Assumes unused entries are held low.
`timescale 1ns/100ps
`default_nettype none

module lic_group_arb (
	// Requests of the group, lowest level first
	input wire logic [2:0] req_in,
	// 0: entry 0 above the others, 1: the others above entry 0
	input wire logic first_low_in,
	// 0: entry 1 above entry 2, 1: entry 2 above entry 1
	input wire logic pair_swap_in,
	// Result
	output logic any_out,
	output logic [1:0] pick_out
);

	logic pair_any;
	logic [1:0] pair_pick;

	// Pair ordering, then entry 0 against the pair
	always_comb begin
		pair_any = req_in[1] || req_in[2];
		if (pair_swap_in) begin
			pair_pick = req_in[2] ? 2'h2 : 2'h1;
		end else begin
			pair_pick = req_in[1] ? 2'h1 : 2'h2;
		end
		any_out = req_in[0] || pair_any;
		if (req_in[0] && (!first_low_in || !pair_any)) begin
			pick_out = 2'h0;
		end else begin
			pick_out = pair_pick;
		end
	end

endmodule : lic_group_arb

`default_nettype wire

/* logic/lic_level_interrupt_controller.sv */
// Level interrupt controller top: gathers 26 sources into eight levels,
// holds mask, priority and system mode registers, and hands the winning
// level to the core at the end of an instruction.
// Assumes all inputs are synchronous to ref_clk_in and the core drives the
// register port and instruction strobes as single-cycle pulses.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Level 0 takes first timer overflow, match/capture and stop wake-up; level 1 second timer.
// - Level 2 takes timer 0 requests; level 3 takes timer 1 and timer 2 requests.
// - Level 4 takes detector, watch timer, serial and I2C; level 5 both UARTs.
// - Level 6 takes port 0 pins 0-3; level 7 takes port 3 pins 4-7.
// - Every source has its own enable bit independent of level controls.
// - Reset clears global and fast enable; fast level select has no defined value.
// - Enable instruction sets global enable, disable clears it; direct writes also work.
// - Mask bit n at 0 blocks level n, at 1 lets it through.
// - Mask is undefined after reset; software initialises every bit.
// - All mask bits are readable and writable by register addressing.
// - Priority is undefined after reset; software initialises every bit.
// - Highest-priority level is served first; within a level, lowest vector first.
// - Group A is levels 0-1, B is levels 2-4, C is levels 5-7.
// - Priority bits 7, 4, 1 order groups; 001 gives B>C>A, 101 gives C>B>A.
// - Priority bit 5 orders inside group C, bit 6 orders levels 6 and 7.
// - Priority bit 0 chooses between level 0 and level 1.
// - Status bit n is 1 while a request for level n is outstanding.
// - Status register is read-only, readable any time, cleared by reset.
// - Status keeps updating while disabled; no service until globally enabled.
// - Acknowledge at instruction end only when enabled, unmasked and winning; then clear global enable.
// - Interrupt return sets the global enable again.
// - System mode bits 4-2 name the fast level, active only with fast enable set.
module lic_level_interrupt_controller (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Register port from the core
	input wire lic_pkg::lic_reg_req_type reg_req_in,
	output logic [7:0] reg_rdata_out,
	// Instruction strobes from the core
	input wire logic instr_end_in,
	input wire logic enable_interrupts_instr_in,
	input wire logic disable_interrupts_instr_in,
	input wire logic interrupt_return_instr_in,
	// Interrupt sources, vector order
	input wire logic [lic_pkg::LIC_NUM_SOURCES-1:0] src_pend_in,
	input wire logic [lic_pkg::LIC_NUM_SOURCES-1:0] src_en_in,
	// Status and acknowledge to the core
	output lic_pkg::lic_ack_type ack_out,
	output logic [7:0] level_request_status_out,
	output logic global_enable_out,
	output logic int_pending_out
);

	localparam int NL = lic_pkg::LIC_NUM_LEVELS;
	localparam int IW = lic_pkg::LIC_SRC_IDX_W;

	// Register state
	logic [7:0] level_request_status;
	logic [7:0] level_mask;
	logic [7:0] level_priority;
	logic global_enable_bit;
	logic fast_enable_bit;
	logic [2:0] fast_level_select;
	logic [IW-1:0] level_first [NL];
	logic [7:0] rdata;
	lic_pkg::lic_ack_type ack;
	logic pending;

	logic [7:0] next_level_request_status;
	logic [7:0] next_level_mask;
	logic [7:0] next_level_priority;
	logic next_global_enable_bit;
	logic next_fast_enable_bit;
	logic [2:0] next_fast_level_select;
	logic [IW-1:0] next_level_first [NL];
	logic [7:0] next_rdata;
	lic_pkg::lic_ack_type next_ack;
	logic next_pending;

	// Combinational arbitration signals
	logic [7:0] live_req;
	logic [IW-1:0] live_first [NL];
	logic [7:0] eligible;
	logic [2:0] grp_any;
	logic [1:0] grp_pick [3];
	logic [2:0] order_code;
	logic [1:0] order [3];
	logic win_any;
	logic [2:0] win_level;
	logic [7:0] sym_value;

	// Per-level gather of enabled pending sources
	for (genvar g = 0; g < NL; g++) begin : gen_level
		lic_level_or #(
			.SRC_W(lic_pkg::LIC_NUM_SOURCES),
			.BASE(lic_pkg::LIC_SRC_BASE[g]),
			.COUNT(lic_pkg::LIC_SRC_COUNT[g]),
			.IDX_W(IW)
		) u_level_or (
			.pend_in(src_pend_in),
			.en_in(src_en_in),
			.req_out(live_req[g]),
			.first_out(live_first[g])
		);
	end

	// Masked levels take no part in arbitration
	assign eligible = level_request_status & level_mask;

	// Group A: levels 0 and 1
	lic_group_arb u_group_a (
		.req_in({1'b0, eligible[1], eligible[0]}),
		.first_low_in(level_priority[lic_pkg::LIC_PRI_GROUP_A_BIT]),
		.pair_swap_in(1'b0),
		.any_out(grp_any[0]),
		.pick_out(grp_pick[0])
	);

	// Group B: levels 2, 3 and 4
	lic_group_arb u_group_b (
		.req_in(eligible[4:2]),
		.first_low_in(level_priority[lic_pkg::LIC_PRI_B_FIRST_BIT]),
		.pair_swap_in(level_priority[lic_pkg::LIC_PRI_B_PAIR_BIT]),
		.any_out(grp_any[1]),
		.pick_out(grp_pick[1])
	);

	// Group C: levels 5, 6 and 7
	lic_group_arb u_group_c (
		.req_in(eligible[7:5]),
		.first_low_in(level_priority[lic_pkg::LIC_PRI_C_FIRST_BIT]),
		.pair_swap_in(level_priority[lic_pkg::LIC_PRI_C_PAIR_BIT]),
		.any_out(grp_any[2]),
		.pick_out(grp_pick[2])
	);

	// Group order from priority bits 7, 4 and 1; unused codes fall back to A>B>C
	always_comb begin
		order_code = {level_priority[lic_pkg::LIC_PRI_ORDER_HI_BIT],
			level_priority[lic_pkg::LIC_PRI_ORDER_MID_BIT],
			level_priority[lic_pkg::LIC_PRI_ORDER_LO_BIT]};
		order[0] = 2'h0;
		order[1] = 2'h1;
		order[2] = 2'h2;
		case (order_code)
			lic_pkg::LIC_ORD_B_C_A: begin
				order[0] = 2'h1;
				order[1] = 2'h2;
				order[2] = 2'h0;
			end
			lic_pkg::LIC_ORD_B_A_C: begin
				order[0] = 2'h1;
				order[1] = 2'h0;
				order[2] = 2'h2;
			end
			lic_pkg::LIC_ORD_C_A_B: begin
				order[0] = 2'h2;
				order[1] = 2'h0;
				order[2] = 2'h1;
			end
			lic_pkg::LIC_ORD_C_B_A: begin
				order[0] = 2'h2;
				order[1] = 2'h1;
				order[2] = 2'h0;
			end
			lic_pkg::LIC_ORD_A_C_B: begin
				order[0] = 2'h0;
				order[1] = 2'h2;
				order[2] = 2'h1;
			end
			default: begin
				order[0] = 2'h0;
				order[1] = 2'h1;
				order[2] = 2'h2;
			end
		endcase
	end

	// Winning level: first requesting group in order, then its pick
	always_comb begin
		win_any = 1'b0;
		win_level = 3'h0;
		for (int k = 2; k >= 0; k--) begin
			if (grp_any[order[k]]) begin
				win_any = 1'b1;
				unique case (order[k])
					2'h0: win_level = {2'h0, grp_pick[0][0]};
					2'h1: win_level = {1'b0, grp_pick[1]} + 3'h2;
					default: win_level = {1'b0, grp_pick[2]} + 3'h5;
				endcase
			end
		end
	end

	// Read image of the system mode register
	assign sym_value = {3'h0, fast_level_select, fast_enable_bit, global_enable_bit};

	// Next values of registers, status, read data and acknowledge
	always_comb begin
		next_level_request_status = live_req;
		for (int l = 0; l < NL; l++) begin
			next_level_first[l] = live_first[l];
		end
		next_level_mask = level_mask;
		next_level_priority = level_priority;
		next_global_enable_bit = global_enable_bit;
		next_fast_enable_bit = fast_enable_bit;
		next_fast_level_select = fast_level_select;
		next_rdata = rdata;
		next_ack = '0;
		next_pending = global_enable_bit && win_any;
		// Direct register writes; the status register ignores writes
		if (reg_req_in.wr) begin
			unique case (reg_req_in.addr)
				lic_pkg::LIC_OFS_LEVEL_MASK: next_level_mask = reg_req_in.wdata;
				lic_pkg::LIC_OFS_LEVEL_PRIORITY: next_level_priority = reg_req_in.wdata;
				lic_pkg::LIC_OFS_SYSTEM_MODE: begin
					next_global_enable_bit = reg_req_in.wdata[lic_pkg::LIC_SYM_GLOBAL_ENABLE_BIT];
					next_fast_enable_bit = reg_req_in.wdata[lic_pkg::LIC_SYM_FAST_ENABLE_BIT];
					next_fast_level_select =
						reg_req_in.wdata[lic_pkg::LIC_SYM_FAST_SEL_HI:lic_pkg::LIC_SYM_FAST_SEL_LO];
				end
				default: ;
			endcase
		end
		// Instruction strobes override a direct write in the same cycle
		if (enable_interrupts_instr_in || interrupt_return_instr_in) begin
			next_global_enable_bit = 1'b1;
		end
		if (disable_interrupts_instr_in) begin
			next_global_enable_bit = 1'b0;
		end
		// Acknowledge at instruction end, which disables further service
		if (instr_end_in && global_enable_bit && win_any) begin
			next_ack.valid = 1'b1;
			next_ack.level = win_level;
			next_ack.source = level_first[win_level];
			next_ack.fast = fast_enable_bit && (fast_level_select == win_level);
			next_global_enable_bit = 1'b0;
			next_pending = 1'b0;
		end
		// Read data, held between reads
		if (reg_req_in.rd) begin
			unique case (reg_req_in.addr)
				lic_pkg::LIC_OFS_LEVEL_REQUEST_STATUS: next_rdata = level_request_status;
				lic_pkg::LIC_OFS_LEVEL_MASK: next_rdata = level_mask;
				lic_pkg::LIC_OFS_SYSTEM_MODE: next_rdata = sym_value;
				lic_pkg::LIC_OFS_LEVEL_PRIORITY: next_rdata = level_priority;
				default: next_rdata = lic_pkg::LIC_RDATA_UNMAPPED;
			endcase
		end
	end

	// State registers
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_request_status <= lic_pkg::LIC_RST_LEVEL_REQUEST_STATUS;
			level_mask <= lic_pkg::LIC_RST_LEVEL_MASK;
			level_priority <= lic_pkg::LIC_RST_LEVEL_PRIORITY;
			global_enable_bit <= 1'b0;
			fast_enable_bit <= 1'b0;
			fast_level_select <= lic_pkg::LIC_RST_FAST_LEVEL_SELECT;
			for (int l = 0; l < NL; l++) begin
				level_first[l] <= '0;
			end
			rdata <= lic_pkg::LIC_RDATA_UNMAPPED;
			ack <= '0;
			pending <= 1'b0;
		end else begin
			level_request_status <= next_level_request_status;
			level_mask <= next_level_mask;
			level_priority <= next_level_priority;
			global_enable_bit <= next_global_enable_bit;
			fast_enable_bit <= next_fast_enable_bit;
			fast_level_select <= next_fast_level_select;
			for (int l = 0; l < NL; l++) begin
				level_first[l] <= next_level_first[l];
			end
			rdata <= next_rdata;
			ack <= next_ack;
			pending <= next_pending;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_out = rdata;
	assign ack_out = ack;
	assign level_request_status_out = level_request_status;
	assign global_enable_out = global_enable_bit;
	assign int_pending_out = pending;

endmodule : lic_level_interrupt_controller

`default_nettype wire

/* tb/lic_assertions.sv */
// Port-level assertions for the level interrupt controller top.
// Assumes the core drives register accesses and strobes as one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module lic_assertions (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Core side
	input wire lic_pkg::lic_reg_req_type reg_req_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic instr_end_in,
	input wire logic enable_interrupts_instr_in,
	input wire logic disable_interrupts_instr_in,
	input wire logic interrupt_return_instr_in,
	// Sources and results
	input wire logic [lic_pkg::LIC_NUM_SOURCES-1:0] src_pend_in,
	input wire logic [lic_pkg::LIC_NUM_SOURCES-1:0] src_en_in,
	input wire lic_pkg::lic_ack_type ack_out,
	input wire logic [7:0] level_request_status_out,
	input wire logic global_enable_out,
	input wire logic int_pending_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] mask_sh;
	logic [3:0] fast_sh;
	logic [25:0] act;
	logic [7:0] exp_stat;
	logic [7:0] fast_vec;
	logic grant;
	logic rd_mask;
	logic rd_stat;
	logic want_pend;
	// Expected level status, eligibility and decoded register accesses
	assign act = src_pend_in & src_en_in;
	assign exp_stat = {|act[25:22], |act[21:18], |act[17:14], |act[13:10], |act[9:6], |act[5:4], act[3], |act[2:0]};
	assign grant = instr_end_in && global_enable_out && |(level_request_status_out & mask_sh);
	assign fast_vec = fast_sh[0] ? (8'h01 << fast_sh[3:1]) : 8'h00;
	assign rd_mask = reg_req_in.rd && reg_req_in.addr == lic_pkg::LIC_OFS_LEVEL_MASK;
	assign rd_stat = reg_req_in.rd && reg_req_in.addr == lic_pkg::LIC_OFS_LEVEL_REQUEST_STATUS;
	// Pending flag expected from enable and eligible levels, dropped by an acknowledge
	assign want_pend = global_enable_out && !instr_end_in && |(level_request_status_out & mask_sh);
	// Shadow copies of the mask and the fast fields
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mask_sh <= 8'h00;
			fast_sh <= 4'h0;
		end else if (reg_req_in.wr && reg_req_in.addr == lic_pkg::LIC_OFS_LEVEL_MASK) begin
			mask_sh <= reg_req_in.wdata;
		end else if (reg_req_in.wr && reg_req_in.addr == lic_pkg::LIC_OFS_SYSTEM_MODE) begin
			fast_sh <= reg_req_in.wdata[4:1];
		end
	end
	property p_status_map;
		1'b1 |=> level_request_status_out == $past(exp_stat);
	endproperty
	a_status_map: assert property (p_status_map) else $error("status map wrong");
	property p_ack_cause;
		1'b1 |=> ack_out.valid == $past(grant);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack cause wrong");
	property p_ack_clears;
		ack_out.valid |-> !global_enable_out;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("enable kept on ack");
	property p_ack_unmasked;
		ack_out.valid |-> |($past(level_request_status_out) & $past(mask_sh) & (8'h01 << ack_out.level));
	endproperty
	a_ack_unmasked: assert property (p_ack_unmasked) else $error("ack level not eligible");
	property p_fast;
		ack_out.valid |-> ack_out.fast == |($past(fast_vec) & (8'h01 << ack_out.level));
	endproperty
	a_fast: assert property (p_fast) else $error("fast flag wrong");
	property p_ei;
		enable_interrupts_instr_in && !disable_interrupts_instr_in && !instr_end_in |=> global_enable_out;
	endproperty
	a_ei: assert property (p_ei) else $error("enable instruction lost");
	property p_di;
		disable_interrupts_instr_in |=> !global_enable_out;
	endproperty
	a_di: assert property (p_di) else $error("disable instruction lost");
	property p_interrupt_return_instr;
		interrupt_return_instr_in && !disable_interrupts_instr_in && !instr_end_in |=> global_enable_out;
	endproperty
	a_interrupt_return_instr: assert property (p_interrupt_return_instr) else $error("return did not enable");
	property p_wr_ge;
		reg_req_in.wr && reg_req_in.addr == lic_pkg::LIC_OFS_SYSTEM_MODE && reg_req_in.wdata[0]
			&& !disable_interrupts_instr_in && !instr_end_in |=> global_enable_out;
	endproperty
	a_wr_ge: assert property (p_wr_ge) else $error("direct enable write lost");
	property p_rd_mask;
		rd_mask |=> reg_rdata_out == $past(mask_sh);
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");
	property p_rd_status;
		rd_stat |=> reg_rdata_out == $past(level_request_status_out);
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status read wrong");
	property p_pending;
		1'b1 |=> int_pending_out == $past(want_pend);
	endproperty
	a_pending: assert property (p_pending) else $error("pending flag wrong");
	property p_reset;
		$rose(resetn_in) |-> !global_enable_out && level_request_status_out == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule : lic_assertions
bind lic_level_interrupt_controller lic_assertions lic_assertions_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
	.reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .instr_end_in(instr_end_in),
	.enable_interrupts_instr_in(enable_interrupts_instr_in), .disable_interrupts_instr_in(disable_interrupts_instr_in),
	.interrupt_return_instr_in(interrupt_return_instr_in), .src_pend_in(src_pend_in), .src_en_in(src_en_in),
	.ack_out(ack_out), .level_request_status_out(level_request_status_out),
	.global_enable_out(global_enable_out), .int_pending_out(int_pending_out));
`default_nettype wire

/* tb/lic_core_model.sv */
// Model of the CPU core: register accesses, instruction strobes, start-up.
// Assumes the controller samples requests on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module lic_core_model (
	// Clock
	input wire logic ref_clk_in,
	// Register port
	output lic_pkg::lic_reg_req_type reg_req_out,
	input wire logic [7:0] reg_rdata_in,
	// Instruction strobes
	output logic instr_end_out,
	output logic enable_interrupts_instr_out,
	output logic disable_interrupts_instr_out,
	output logic interrupt_return_instr_out,
	// Acknowledge
	input wire lic_pkg::lic_ack_type ack_in
);
	// Idle port at time zero
	initial begin
		reg_req_out = '0;
		{interrupt_return_instr_out, disable_interrupts_instr_out, enable_interrupts_instr_out, instr_end_out} = 4'h0;
	end
	// One register access; the idle bus never shows the last address or data
	task automatic access(input logic rd, input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		@(negedge ref_clk_in);
		reg_req_out = {rd, wr, addr, wdata};
		@(negedge ref_clk_in);
		rdata = reg_rdata_in;
		reg_req_out = {1'b0, 1'b0, ~addr, ~wdata};
	endtask : access
	// One strobe cycle: return, disable, enable, end of instruction
	task automatic pulse(input logic [3:0] sel, output lic_pkg::lic_ack_type ack);
		@(negedge ref_clk_in);
		{interrupt_return_instr_out, disable_interrupts_instr_out, enable_interrupts_instr_out, instr_end_out} = sel;
		@(negedge ref_clk_in);
		ack = ack_in;
		{interrupt_return_instr_out, disable_interrupts_instr_out, enable_interrupts_instr_out, instr_end_out} = 4'h0;
	endtask : pulse
	// Start-up: disable, program mask and priority, then enable
	task automatic init(input logic [7:0] mask, input logic [7:0] prio);
		lic_pkg::lic_ack_type a;
		logic [7:0] d;
		pulse(4'h4, a);
		access(1'b0, 1'b1, lic_pkg::LIC_OFS_LEVEL_MASK, mask, d);
		access(1'b0, 1'b1, lic_pkg::LIC_OFS_LEVEL_PRIORITY, prio, d);
		pulse(4'h2, a);
	endtask : init
endmodule : lic_core_model
`default_nettype wire

/* tb/tb.sv */
// Testbench for the level interrupt controller: registers, source map,
// arbitration, global enable and acknowledge. Assumes the core model.
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [7:0] ST = lic_pkg::LIC_OFS_LEVEL_REQUEST_STATUS;
	localparam logic [7:0] MK = lic_pkg::LIC_OFS_LEVEL_MASK;
	localparam logic [7:0] SM = lic_pkg::LIC_OFS_SYSTEM_MODE;
	localparam logic [7:0] PR = lic_pkg::LIC_OFS_LEVEL_PRIORITY;
	localparam int base [8] = '{0, 3, 4, 6, 10, 14, 18, 22};
	// Priority, mask, system mode, fast flag and winning level
	localparam logic [31:0] tab [17] = '{32'h00FF0100, 32'h01FF0101, 32'h02FF0102, 32'h06FF0103,
		32'h0EFF0104, 32'h82FF170D, 32'hA2FF0106, 32'hE2FF1B07, 32'h02030100, 32'h801C0102,
		32'h10FC0102, 32'h90FC0105, 32'h12E30100, 32'h80FF1505, 32'h02E00105, 32'h821F0102, 32'h92FF0100};
	logic clk;
	logic resetn;
	logic [25:0] pend;
	logic [25:0] en;
	lic_pkg::lic_reg_req_type req;
	logic [7:0] rdata;
	logic iend;
	logic ei;
	logic di;
	logic interrupt_return_instr;
	lic_pkg::lic_ack_type ack_w;
	lic_pkg::lic_ack_type ack;
	logic [7:0] status;
	logic ge;
	logic ipend;
	logic [7:0] d;
	int num_errors = 0;
	int comparisons = 0;
	lic_level_interrupt_controller lic_level_interrupt_controller_i (.ref_clk_in(clk), .resetn_in(resetn),
		.reg_req_in(req), .reg_rdata_out(rdata), .instr_end_in(iend), .enable_interrupts_instr_in(ei),
		.disable_interrupts_instr_in(di), .interrupt_return_instr_in(interrupt_return_instr), .src_pend_in(pend), .src_en_in(en),
		.ack_out(ack_w), .level_request_status_out(status), .global_enable_out(ge), .int_pending_out(ipend));
	lic_core_model lic_core_model_i (.ref_clk_in(clk), .reg_req_out(req), .reg_rdata_in(rdata),
		.instr_end_out(iend), .enable_interrupts_instr_out(ei), .disable_interrupts_instr_out(di),
		.interrupt_return_instr_out(interrupt_return_instr), .ack_in(ack_w));
	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Status bit expected for one source
	function automatic logic [7:0] lvl_bit(input int s);
		int l;
		l = 0;
		for (int k = 1; k < 8; k++) if (s >= base[k]) l = k;
		return 8'h01 << l;
	endfunction : lvl_bit
	// Comparisons
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_byte
	task automatic check_ack(input lic_pkg::lic_ack_type got, input lic_pkg::lic_ack_type exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_ack
	// Register access
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] x;
		lic_core_model_i.access(1'b0, 1'b1, a, v, x);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		lic_core_model_i.access(1'b1, 1'b0, a, 8'h00, v);
	endtask : rd_reg
	// Verdict
	task automatic test_done();
		if (num_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// Cuts a hung run short
	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		test_done();
	end
	// Main sequence
	initial begin
		resetn = 1'b0;
		pend = '0;
		en = '0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		rd_reg(ST, d);
		check_byte(d, 8'h00);
		rd_reg(SM, d);
		check_byte(d & 8'h03, 8'h00);
		wr_reg(ST, 8'hFF);
		rd_reg(ST, d);
		check_byte(d, 8'h00);
		rd_reg(8'h10, d);
		check_byte(d, 8'h00);
		lic_core_model_i.init(8'h00, 8'h00);
		check_byte({7'h0, ge}, 8'h01);
		// Each source lights its own level, only while enabled
		for (int s = 0; s < 26; s++) begin
			pend = 26'h1 << s;
			en = pend;
			@(negedge clk);
			check_byte(status, lvl_bit(s));
			en = '0;
			@(negedge clk);
			check_byte(status, 8'h00);
		end
		lic_core_model_i.pulse(4'h4, ack);
		check_byte({7'h0, ge}, 8'h00);
		wr_reg(MK, 8'hA5);
		rd_reg(MK, d);
		check_byte(d, 8'hA5);
		// Arbitration with every source requesting
		pend = '1;
		en = '1;
		for (int i = 0; i < 17; i++) begin
			wr_reg(PR, tab[i][31:24]);
			wr_reg(MK, tab[i][23:16]);
			wr_reg(SM, tab[i][15:8]);
			lic_core_model_i.pulse(4'h1, ack);
			check_ack(ack, {1'b1, tab[i][2:0], 5'(base[tab[i][2:0]]), tab[i][3]});
			check_byte({7'h0, ge}, 8'h00);
		end
		// Held while disabled, served once enabled, re-enabled by return
		wr_reg(MK, 8'h04);
		lic_core_model_i.pulse(4'h1, ack);
		check_byte({7'h0, ack.valid}, 8'h00);
		check_byte(status, 8'hFF);
		lic_core_model_i.pulse(4'h2, ack);
		lic_core_model_i.pulse(4'h1, ack);
		check_ack(ack, {1'b1, 3'h2, 5'h04, 1'b0});
		lic_core_model_i.pulse(4'h8, ack);
		check_byte({7'h0, ge}, 8'h01);
		// A masked level is never served
		wr_reg(MK, 8'h00);
		lic_core_model_i.pulse(4'h1, ack);
		check_byte({6'h0, ack.valid, ipend}, 8'h00);
		wr_reg(SM, 8'h00);
		check_byte({7'h0, ge}, 8'h00);
		test_done();
	end
endmodule : tb
`default_nettype wire
